// ==== core/uart_status_pkg.sv ====
// Purpose: shared constants and carriers for the serial port status logic
// Assumes: 32-bit register bus, byte addresses, one word per register
// Notes:   fifo depths and thresholds are defaults; ports may override the transmit fifo depth
package uart_status_pkg;

  // register byte addresses
  localparam logic [31:0] ADDR_EVENT_STATUS = 32'h8005_001C;
  localparam logic [31:0] ADDR_LINE_FLAGS   = 32'h8005_0020;
  localparam logic [31:0] ADDR_CONTROL      = 32'h8005_0024;

  // event status field positions
  localparam int TX_SERVICE_BIT  = 0;
  localparam int RX_SERVICE_BIT  = 1;
  localparam int RX_IDLE_BIT     = 2;
  localparam int BREAK_BEGIN_BIT = 3;
  localparam int BREAK_END_BIT   = 4;
  localparam int ERROR_SUM_BIT   = 5;

  // control field positions
  localparam int TX_ENABLE_BIT     = 0;
  localparam int RX_ENABLE_BIT     = 1;
  localparam int TX_IRQ_ENABLE_BIT = 2;
  localparam int RX_IRQ_ENABLE_BIT = 3;

  // reset values
  localparam logic [5:0] EVENT_RESET   = 6'h00;
  localparam logic [3:0] CONTROL_RESET = 4'h0;

  // fifo geometry and service thresholds
  localparam int TX_FIFO_DEPTH    = 8;
  localparam int RX_FIFO_DEPTH    = 12;
  localparam int COUNT_WIDTH      = 4;
  localparam int TX_SERVICE_MAX   = 4;
  localparam int RX_SERVICE_SET   = 8;
  localparam int ERROR_WINDOW     = 4;
  localparam int IDLE_FRAMES      = 3;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // software controls of the port
  typedef struct packed {
    logic rxIrqEnable;
    logic txIrqEnable;
    logic rxEnable;
    logic txEnable;
  } ctrl_type;

  // error tags of one receive fifo entry
  typedef struct packed {
    logic overrun;
    logic framing;
    logic parity;
  } error_tag_type;

endpackage : uart_status_pkg

// ==== core/uart_bit_sync.sv ====
// Purpose: two flip-flop synchroniser for one asynchronous level
// Assumes: input may change at any time relative to clk
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module uart_bit_sync
  import uart_status_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b1
)(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic metaQ;
  logic metaD;
  logic syncD;

  // next values; idle line level held through reset
  always_comb
  begin
    metaD = resetn ? asyncIn : RESET_LEVEL;
    syncD = resetn ? metaQ : RESET_LEVEL;
  end

  // two stages
  always_ff @(posedge clk)
  begin
    metaQ   <= metaD;
    syncOut <= syncD;
  end

endmodule : uart_bit_sync

// ==== core/uart_idle_timer.sv ====
// Purpose: counts frame periods of silence and flags receiver idle once
// Assumes: frameTick is a one-cycle pulse per frame time from the baud divider
// Notes:   fires once per silence; activity or disarm restarts the count
`timescale 1ns/1ps
module uart_idle_timer
  import uart_status_pkg::*;
#(
  parameter int FRAMES = IDLE_FRAMES
)(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic armed,
  input  wire logic frameTick,
  input  wire logic rxActivity,
  output logic      idleHit
);

  logic [2:0] count_q;
  logic [2:0] count_d;
  logic       idleHit_d;

  // saturate at FRAMES so one silence gives one pulse
  always_comb
  begin
    count_d   = count_q;
    idleHit_d = 1'b0;
    if (!armed || rxActivity)
      count_d = 3'h0;
    else if (frameTick && count_q != 3'(FRAMES))
    begin
      count_d = count_q + 3'h1;
      if (count_d == 3'(FRAMES))
        idleHit_d = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      count_q <= 3'h0;
      idleHit <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      idleHit <= idleHit_d;
    end
  end

endmodule : uart_idle_timer

// ==== core/uart_status_flag_logic.sv ====
// Purpose: status and flag logic of the serial port with its register slave
// Assumes: fifo counts, tags and pulses come from logic on clk; rxPin is async
// Notes:   sticky bits reset to zero; software still clears them before enabling
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps

// Overview of operation
// RULE1: rising receive line with interlock sets break end
// RULE2: break end raises request, releases interlock
// RULE3: break end only re-arms after new break begin
// RULE4: bit5 reflects error tags of bottom four entries
// RULE5: error summary requests interrupt, blocks receive dma
// RULE6: software drains errored entries until summary clears
// RULE7: software clears sticky bits before enabling port
// RULE8: reserved upper bits ignore writes, read zero
// RULE9: bit0 set at four or fewer transmit entries
// RULE10: bit1 set when receive fifo well filled
// RULE11: bit2 set after three silent frames, not empty
// RULE12: bit3 on null break frame, store only one
// RULE13: bit4 break end; bits0-5 each request interrupt; code gates bits0-2 with txIrqEnable and rxIrqEnable
// RULE14: busy flag follows shifter, no interrupt; code holds it low while txEnable is clear
// RULE15: not-empty flag set with any valid byte
// RULE16: software polls not-empty to drain remainder
// RULE17: not-full flag clears only when fifo full
// RULE18: second register read-only, never interrupts
// RULE19: write one clears sticky bit, zero keeps
// RULE20: interrupt request holds while bit stays set
// RULE21: interlock released by break end, disable, reset
// RULE22: receive service sets at eight, clears seven
module uart_status_flag_logic
  import uart_status_pkg::*;
#(
  parameter int TX_DEPTH = TX_FIFO_DEPTH
)(
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // axi4-lite slave
  input  wire logic [31:0]              awaddr,
  input  wire logic                     awvalid,
  output logic                          awready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready,
  output logic [1:0]                    bresp,
  output logic                          bvalid,
  input  wire logic                     bready,
  input  wire logic [31:0]              araddr,
  input  wire logic                     arvalid,
  output logic                          arready,
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  output logic                          rvalid,
  input  wire logic                     rready,
  // datapath side
  input  wire logic                     rxPin,
  input  wire logic [COUNT_WIDTH-1:0]   txCount,
  input  wire logic [COUNT_WIDTH-1:0]   rxCount,
  input  wire error_tag_type [ERROR_WINDOW-1:0] bottomTags,
  input  wire logic                     txShifterBusy,
  input  wire logic                     frameTick,
  input  wire logic                     rxFrameDone,
  input  wire logic                     nullBreakFrame,
  // service requests and datapath controls
  output logic                          txDmaReq,
  output logic                          rxDmaReq,
  output logic                          irqReq,
  output logic [5:0]                    irqVector,
  output logic                          breakInterlock,
  output ctrl_type                      portCtrl
);

  logic       rxLine;
  logic       rxLinePrev_q;
  logic       idleHit;
  logic       rxRise;

  logic       txService_d, rxService_d, errorSum_d;
  logic       txService_q, rxService_q, errorSum_q;
  logic       rxIdle_d, breakBegin_d, breakEnd_d, interlock_d;
  logic       rxIdle_q, breakBegin_q, breakEnd_q;
  logic [5:0] events_d;
  logic [5:0] irqVector_d;
  ctrl_type   ctrl_d;

  logic [31:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0]  wStrb_q, wStrb_d;
  logic        awHeld_q, awHeld_d, wHeld_q, wHeld_d;
  logic        doWrite;
  logic        bvalid_d, rvalid_d;
  logic [1:0]  bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic [7:0]  lineFlags;

  // the receive pin crosses into clk before anything looks at it
  uart_bit_sync #(
    .RESET_LEVEL (1'b1)
  ) u_rx_sync (
    .clk     (clk),
    .resetn  (resetn),
    .asyncIn (rxPin),
    .syncOut (rxLine)
  );

  // silence counter, armed only with receiver on and data waiting
  uart_idle_timer #(
    .FRAMES (IDLE_FRAMES)
  ) u_idle (
    .clk        (clk),
    .resetn     (resetn),
    .armed      (portCtrl.rxEnable && rxCount != '0),
    .frameTick  (frameTick),
    .rxActivity (rxFrameDone),
    .idleHit    (idleHit)
  );

  assign rxRise = rxLine && !rxLinePrev_q;

  // bus write channels; address and data may arrive in either order
  always_comb
  begin
    awAddr_d = awAddr_q;
    wData_d  = wData_q;
    wStrb_d  = wStrb_q;
    awHeld_d = awHeld_q;
    wHeld_d  = wHeld_q;
    bvalid_d = bvalid && !bready;
    bresp_d  = bresp;
    doWrite  = 1'b0;
    if (awvalid && awready)
    begin
      awAddr_d = awaddr;
      awHeld_d = 1'b1;
    end
    if (wvalid && wready)
    begin
      wData_d = wdata;
      wStrb_d = wstrb;
      wHeld_d = 1'b1;
    end
    if (awHeld_q && wHeld_q && !bvalid)
    begin
      doWrite  = 1'b1;
      awHeld_d = 1'b0;
      wHeld_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = (awAddr_q == ADDR_EVENT_STATUS || awAddr_q == ADDR_LINE_FLAGS ||
                  awAddr_q == ADDR_CONTROL) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // live line flags; register is read-only and drives no interrupt
  always_comb
  begin
    lineFlags    = 8'h00;                                      // RULE18
    lineFlags[0] = txShifterBusy && portCtrl.txEnable;         // RULE14
    lineFlags[1] = rxCount != '0;                              // RULE15
    lineFlags[2] = txCount != COUNT_WIDTH'(TX_DEPTH);          // RULE17
    lineFlags[5:3] = bottomTags[0];
  end

  // read channel; one read at a time, data held until taken
  always_comb
  begin
    rvalid_d = rvalid && !rready;
    rdata_d  = rdata;
    rresp_d  = rresp;
    if (arvalid && arready)
    begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      case (araddr)
        ADDR_EVENT_STATUS: rdata_d = {26'h0, irqVector_status()};  // RULE8
        ADDR_LINE_FLAGS:   rdata_d = {24'h0, lineFlags};
        ADDR_CONTROL:      rdata_d = {28'h0, portCtrl};
        default:
        begin
          rdata_d = 32'h0;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  function automatic logic [5:0] irqVector_status();
    irqVector_status = {errorSum_q, breakEnd_q, breakBegin_q, rxIdle_q, rxService_q, txService_q};
  endfunction : irqVector_status

  // status bits; hardware set wins over a same-cycle software clear
  always_comb
  begin
    logic wrEvent;
    logic [5:0] clr;
    wrEvent = doWrite && awAddr_q == ADDR_EVENT_STATUS && wStrb_q[0];
    clr     = wrEvent ? wData_q[5:0] : 6'h00;                  // RULE8
    ctrl_d  = portCtrl;
    if (doWrite && awAddr_q == ADDR_CONTROL && wStrb_q[0])
      ctrl_d = ctrl_type'(wData_q[3:0]);

    txService_d = ctrl_d.txEnable && txCount <= COUNT_WIDTH'(TX_SERVICE_MAX);    // RULE9
    rxService_d = ctrl_d.rxEnable && rxCount >= COUNT_WIDTH'(RX_SERVICE_SET);    // RULE10 RULE22
    errorSum_d  = |bottomTags;                                                   // RULE4

    rxIdle_d = (rxIdle_q && !clr[RX_IDLE_BIT]) || idleHit;                       // RULE11 RULE19
    // only the first null frame of a break is flagged; the interlock masks the rest
    breakBegin_d = (breakBegin_q && !clr[BREAK_BEGIN_BIT]) ||
                   (nullBreakFrame && !breakInterlock && ctrl_d.rxEnable);       // RULE12
    breakEnd_d   = (breakEnd_q && !clr[BREAK_END_BIT]) ||
                   (rxRise && breakInterlock);                                   // RULE1 RULE3

    interlock_d = breakInterlock;
    if (nullBreakFrame && !breakInterlock && ctrl_d.rxEnable)
      interlock_d = 1'b1;
    if ((rxRise && breakInterlock) || !ctrl_d.rxEnable)
      interlock_d = 1'b0;                                                        // RULE2 RULE21

    events_d = {errorSum_d, breakEnd_d, breakBegin_d, rxIdle_d, rxService_d, txService_d};
    // each bit its own request, level while set; masks only on service and idle
    irqVector_d = events_d;                                                      // RULE13 RULE20
    irqVector_d[TX_SERVICE_BIT] = txService_d && ctrl_d.txIrqEnable;
    irqVector_d[RX_SERVICE_BIT] = rxService_d && ctrl_d.rxIrqEnable;
    irqVector_d[RX_IDLE_BIT]    = rxIdle_d && ctrl_d.rxIrqEnable;
  end

  // all registers; outputs come straight from these flops
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      awAddr_q       <= 32'h0;
      wData_q        <= 32'h0;
      wStrb_q        <= 4'h0;
      awHeld_q       <= 1'b0;
      wHeld_q        <= 1'b0;
      awready        <= 1'b0;
      wready         <= 1'b0;
      bvalid         <= 1'b0;
      bresp          <= RESP_OKAY;
      arready        <= 1'b0;
      rvalid         <= 1'b0;
      rdata          <= 32'h0;
      rresp          <= RESP_OKAY;
      rxLinePrev_q   <= 1'b1;
      portCtrl       <= ctrl_type'(CONTROL_RESET);
      {errorSum_q, breakEnd_q, breakBegin_q, rxIdle_q, rxService_q, txService_q} <= EVENT_RESET;
      breakInterlock <= 1'b0;                                                    // RULE21
      irqVector      <= 6'h00;
      irqReq         <= 1'b0;
      txDmaReq       <= 1'b0;
      rxDmaReq       <= 1'b0;
    end
    else
    begin
      awAddr_q       <= awAddr_d;
      wData_q        <= wData_d;
      wStrb_q        <= wStrb_d;
      awHeld_q       <= awHeld_d;
      wHeld_q        <= wHeld_d;
      awready        <= !awHeld_d;
      wready         <= !wHeld_d;
      bvalid         <= bvalid_d;
      bresp          <= bresp_d;
      arready        <= !rvalid_d;
      rvalid         <= rvalid_d;
      rdata          <= rdata_d;
      rresp          <= rresp_d;
      rxLinePrev_q   <= rxLine;
      portCtrl       <= ctrl_d;
      {errorSum_q, breakEnd_q, breakBegin_q, rxIdle_q, rxService_q, txService_q} <= events_d;
      breakInterlock <= interlock_d;
      irqVector      <= irqVector_d;
      irqReq         <= |irqVector_d;
      txDmaReq       <= txService_d;                                             // RULE9
      rxDmaReq       <= rxService_d && !errorSum_d;                              // RULE5
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_break_end_cause;
    $rose(breakEnd_q) |-> $past(rxRise) && $past(breakInterlock);
  endproperty
  a_break_end_cause: assert property (p_break_end_cause) else $error("break end without locked rise"); // RULE1

  property p_break_end_release;
    $rose(breakEnd_q) |-> !breakInterlock && irqVector[BREAK_END_BIT] && irqReq;
  endproperty
  a_break_end_release: assert property (p_break_end_release) else $error("break end kept lock or no irq"); // RULE2

  property p_error_summary;
    ##1 errorSum_q == |$past(bottomTags);
  endproperty
  a_error_summary: assert property (p_error_summary) else $error("error summary mismatch"); // RULE4

  property p_error_blocks_dma;
    errorSum_q |-> !rxDmaReq && irqReq;
  endproperty
  a_error_blocks_dma: assert property (p_error_blocks_dma) else $error("receive dma while error summary"); // RULE5

  property p_reserved_zero;
    rvalid |-> rdata[31:6] == 26'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero"); // RULE8

  property p_tx_service;
    portCtrl.txEnable && txCount <= 4'h4 && !(doWrite && awAddr_q == ADDR_CONTROL) |=> txDmaReq;
  endproperty
  a_tx_service: assert property (p_tx_service) else $error("transmit service missing"); // RULE9

  property p_rx_service;
    !portCtrl.rxEnable || rxCount <= 4'h7 |=> !rxService_q || $past(doWrite);
  endproperty
  a_rx_service: assert property (p_rx_service) else $error("receive service not cleared"); // RULE22

  property p_idle_cause;
    $rose(rxIdle_q) |-> $past(idleHit);
  endproperty
  a_idle_cause: assert property (p_idle_cause) else $error("idle set without silence"); // RULE11

  property p_level_irq;
    breakBegin_q |-> irqReq;
  endproperty
  a_level_irq: assert property (p_level_irq) else $error("break begin without request"); // RULE20

endmodule : uart_status_flag_logic

// ==== dv/uart_line_partner.sv ====
// Purpose: remote serial station on the receive line
// Assumes: one frame time is FRAME_CYCLES clocks
// Notes:   line idles high; frame ticks come only from silence periods
`timescale 1ns/1ps
module uart_line_partner #(
  parameter int FRAME_CYCLES = 8
)(
  input  wire logic clk,
  output logic      rxPin,
  output logic      nullBreakFrame,
  output logic      rxFrameDone,
  output logic      frameTick
);
  // idle line at time zero
  initial
  begin
    rxPin = 1'b1;
    nullBreakFrame = 1'b0;
    rxFrameDone = 1'b0;
    frameTick = 1'b0;
  end

  // quiet frame periods, one tick pulse each
  task automatic silence(input int n);
    repeat (n)
    begin
      repeat (FRAME_CYCLES - 1) @(posedge clk);
      frameTick <= 1'b1;
      @(posedge clk);
      frameTick <= 1'b0;
    end
  endtask : silence

  // one ordinary frame landing in the fifo
  task automatic send_frame();
    @(posedge clk);
    rxFrameDone <= 1'b1;
    @(posedge clk);
    rxFrameDone <= 1'b0;
  endtask : send_frame

  // line low for a whole frame: null char, zero stop bit
  task automatic send_break();
    @(posedge clk);
    rxPin <= 1'b0;
    repeat (FRAME_CYCLES) @(posedge clk);
    nullBreakFrame <= 1'b1;
    @(posedge clk);
    nullBreakFrame <= 1'b0;
  endtask : send_break

  // line pulled low without a null frame; no break begin follows
  task automatic line_low(input int n);
    @(posedge clk);
    rxPin <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : line_low

  // line released; margin covers the two-flop synchroniser
  task automatic end_break();
    @(posedge clk);
    rxPin <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : end_break
endmodule : uart_line_partner

// ==== dv/test_uart_status_flag_logic.sv ====
// Purpose: register level test of the serial port status logic
// Assumes: axi4-lite master tasks, fifo counts and tags driven directly
// Notes:   only byte 0 of each word is exercised
`timescale 1ns/1ps
module test_uart_status_flag_logic;
  import uart_status_pkg::*;
  localparam logic [31:0] ES = ADDR_EVENT_STATUS;
  localparam logic [31:0] LF = ADDR_LINE_FLAGS;
  localparam logic [31:0] CT = ADDR_CONTROL;
  localparam logic [31:0] NOPE = 32'h8005_0030;
  logic                   clk, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic                   awready, wready, bvalid, arready, rvalid, txShifterBusy;
  logic [31:0]            awaddr, wdata, araddr, rdata;
  logic [1:0]             bresp, rresp;
  logic [3:0]             wstrb;
  logic [COUNT_WIDTH-1:0] txCount, rxCount;
  error_tag_type [ERROR_WINDOW-1:0] bottomTags;
  logic                   rxPin, frameTick, rxFrameDone, nullBreakFrame;
  logic                   txDmaReq, rxDmaReq, irqReq, breakInterlock;
  logic [5:0]             irqVector;
  ctrl_type               portCtrl;
  int                     n_errors, compares;

  uart_status_flag_logic dut_u (
    .clk(clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .rxPin(rxPin),
    .txCount(txCount), .rxCount(rxCount), .bottomTags(bottomTags), .txShifterBusy(txShifterBusy),
    .frameTick(frameTick), .rxFrameDone(rxFrameDone), .nullBreakFrame(nullBreakFrame),
    .txDmaReq(txDmaReq), .rxDmaReq(rxDmaReq), .irqReq(irqReq), .irqVector(irqVector),
    .breakInterlock(breakInterlock), .portCtrl(portCtrl)
  );
  uart_line_partner line_u (
    .clk(clk), .rxPin(rxPin), .nullBreakFrame(nullBreakFrame),
    .rxFrameDone(rxFrameDone), .frameTick(frameTick)
  );

  // verdict and end of run
  task automatic summarize();
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  // word and flag comparisons
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic cmpb(input logic g, input logic e);
    cmp({31'h0, g}, {31'h0, e});
  endtask : cmpb

  // bus write: address and data offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    int i;
    logic done;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50 && !done; i++)
    begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        done = 1'b1;
        bready <= 1'b0;
        cmp({30'h0, bresp}, {30'h0, er});
      end
    end
    if (!done)
    begin
      n_errors++;
      summarize();
    end
    @(posedge clk);
  endtask : wr

  // bus read with expected data and response
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    int i;
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50 && !done; i++)
    begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        done = 1'b1;
        rready <= 1'b0;
        cmp(rdata, e);
        cmp({30'h0, rresp}, {30'h0, er});
      end
    end
    if (!done)
    begin
      n_errors++;
      summarize();
    end
    @(posedge clk);
  endtask : rd

  // settle time after an input change
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // main sequence
  initial
  begin
    {resetn, awvalid, wvalid, bready, arvalid, rready, txShifterBusy} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hF;
    txCount = 4'h8;
    rxCount = 4'h0;
    bottomTags = '0;
    n_errors = 0;
    compares = 0;
    tick(3);
    resetn <= 1'b1;
    tick(1);
    rd(ES, 32'h00);
    wr(ES, 32'h1C);
    wr(CT, 32'h0F);
    cmp({28'h0, portCtrl}, 32'h0F);
    rd(LF, 32'h00);
    txCount <= 4'h4;
    tick(2);
    rd(ES, 32'h01);
    cmpb(txDmaReq, 1'b1);
    cmp({26'h0, irqVector}, 32'h01);
    cmpb(irqReq, 1'b1);
    txCount <= 4'h5;
    rxCount <= 4'h7;
    tick(2);
    rd(ES, 32'h00);
    cmpb(irqReq, 1'b0);
    rxCount <= 4'h8;
    tick(2);
    rd(ES, 32'h02);
    cmpb(rxDmaReq, 1'b1);
    cmp({26'h0, irqVector}, 32'h02);
    bottomTags[3] <= 3'h4;
    tick(2);
    rd(ES, 32'h22);
    cmpb(rxDmaReq, 1'b0);
    cmp({26'h0, irqVector}, 32'h22);
    bottomTags[3] <= 3'h0;
    bottomTags[0] <= 3'h2;
    txShifterBusy <= 1'b1;
    tick(2);
    rd(LF, 32'h17);
    wr(LF, 32'h00);
    rd(LF, 32'h17);
    bottomTags[0] <= 3'h0;
    txShifterBusy <= 1'b0;
    tick(2);
    rd(ES, 32'h02);
    cmpb(rxDmaReq, 1'b1);
    rxCount <= 4'h7;
    tick(2);
    rd(ES, 32'h00);
    cmpb(rxDmaReq, 1'b0);
    rxCount <= 4'h1;
    rd(LF, 32'h06);
    line_u.silence(2);
    line_u.send_frame();
    line_u.silence(2);
    rd(ES, 32'h00);
    line_u.silence(1);
    tick(3);
    rd(ES, 32'h04);
    cmp({26'h0, irqVector}, 32'h04);
    wr(ES, 32'h00);
    rd(ES, 32'h04);
    wr(ES, 32'h04);
    rd(ES, 32'h00);
    rxCount <= 4'h0;
    line_u.send_break();
    tick(2);
    rd(ES, 32'h08);
    cmpb(breakInterlock, 1'b1);
    wr(ES, 32'h08);
    line_u.send_break();
    tick(2);
    rd(ES, 32'h00);
    line_u.end_break();
    rd(ES, 32'h10);
    cmpb(breakInterlock, 1'b0);
    cmp({26'h0, irqVector}, 32'h10);
    wr(ES, 32'h10);
    line_u.line_low(4);
    line_u.end_break();
    rd(ES, 32'h00);
    line_u.send_break();
    tick(2);
    wr(CT, 32'h0D);
    tick(2);
    cmpb(breakInterlock, 1'b0);
    line_u.end_break();
    rd(ES, 32'h08);
    wr(ES, 32'hFF);
    rd(ES, 32'h00);
    rd(NOPE, 32'h00, RESP_SLVERR);
    wr(NOPE, 32'hFF, RESP_SLVERR);
    // busy masked by disabled transmitter; service without its irq enable
    txShifterBusy <= 1'b1;
    wr(CT, 32'h00);
    rd(LF, 32'h04);
    wr(CT, 32'h01);
    txCount <= 4'h4;
    tick(2);
    cmpb(txDmaReq, 1'b1);
    cmp({26'h0, irqVector}, 32'h00);
    cmpb(irqReq, 1'b0);
    wr(CT, 32'h00);
    cmpb(txDmaReq, 1'b0);
    summarize();
  end
endmodule : test_uart_status_flag_logic
